// file: common/apmdc_pkg.sv
// Shared constants, modes and pin-mode decode for the auxiliary pin mux block
package apmdc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] ADDR_SMI_EN2      = 8'hb5;
    localparam logic [7:0] ADDR_PIN_MUX      = 8'hc0;
    localparam logic [7:0] ADDR_FORCE_CHG    = 8'hc1;
    localparam logic [7:0] ADDR_RATE_SHADOW  = 8'hc2;
    localparam logic [7:0] ADDR_U1_FCR       = 8'hc3;
    localparam logic [7:0] ADDR_U2_FCR       = 8'hc4;
    localparam logic [7:0] ADDR_ADDR_QUAL    = 8'hd0;

    // Field positions
    localparam int PMX_DMA3_BIT   = 1;
    localparam int PMX_SERIRQ_BIT = 2;
    localparam int PMX_KBC_BIT    = 3;
    localparam int SMI_IRQ10_BIT  = 7;
    localparam int QUAL_FULL_BIT  = 6;
    localparam int FORCE0_BIT     = 0;
    localparam int FORCE1_BIT     = 1;

    // Implemented-bit masks; reserved bits read as zero
    localparam logic [7:0] PIN_MUX_MASK = 8'h1f;
    localparam logic [7:0] FORCE_MASK   = 8'h03;
    localparam logic [7:0] RATE_MASK    = 8'hdf;
    localparam logic [7:0] FCR_MASK     = 8'hcf;
    localparam logic [7:0] SMI_EN2_MASK = 8'h87;
    localparam logic [7:0] QUAL_MASK    = 8'h40;

    // Reset values
    localparam logic [7:0] PIN_MUX_RST  = 8'h06;
    localparam logic [7:0] FORCE_RST    = 8'h03;
    localparam logic [7:0] SHADOW_RST   = 8'h00;
    localparam logic [7:0] SMI_EN2_RST  = 8'h00;
    localparam logic [7:0] QUAL_RST     = 8'h00;
    localparam logic [7:0] RD_UNMAPPED  = 8'h00;

    // Pin input synchroniser lanes
    localparam int SYN_W     = 10;
    localparam int SYN_STEP  = 0;
    localparam int SYN_DS0   = 1;
    localparam int SYN_DS1   = 2;
    localparam int SYN_DCHG  = 3;
    localparam int SYN_RTS   = 4;
    localparam int SYN_CTS   = 5;
    localparam int SYN_DTR   = 6;
    localparam int SYN_DSR   = 7;
    localparam int SYN_DCD   = 8;
    localparam int SYN_RI    = 9;
    localparam logic [SYN_W-1:0] SYN_RST = 10'h3ff;

    typedef enum logic [1:0] {
        MODE_MODEM = 2'b00,
        MODE_IRQ   = 2'b01,
        MODE_ALT   = 2'b10,
        MODE_RSVD  = 2'b11
    } apmdc_mode_e;

    // Alternate select off: modem or IRQ; on: alternate function or reserved
    function automatic apmdc_mode_e apmdc_pin_mode(input logic alt_sel,
                                                   input logic serirq_sel);
        if (!alt_sel) begin
            return serirq_sel ? MODE_MODEM : MODE_IRQ;
        end
        return serirq_sel ? MODE_ALT : MODE_RSVD;
    endfunction

endpackage

// file: src/apmdc_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module apmdc_sync #(
    parameter int              WIDTH = 1,
    parameter logic [WIDTH-1:0] RST  = '0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= RST;
            q      <= RST;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

// file: src/apmdc_top.sv
// Auxiliary I/O: force disk change flags, shadow registers and modem pin muxes
//
// Notes on behaviour
// - Software writes one set force flags only
// - Step with drive one selected clears flag one
// - Step with drive zero selected clears flag zero
// - Disk changed status combines selects, flags, input
// - Read-only copy of floppy data-rate write
// - Readable copies of both UART FIFO control writes
// - Request-to-send pin: modem, IRQ5 or SA12
// - Clear-to-send pin: modem, IRQ6 or SA13
// - Terminal-ready pin: modem, IRQ7 or SA14
// - Set-ready pin: modem, IRQ10 or SA15
// - Set-ready IRQ carries IRQ10 or management interrupt
// - Carrier-detect pin: modem, IRQ11 or keyboard bit2
// - Ring pin: modem, IRQ12 or keyboard bit6
// - DMA3 request pin: request or keyboard bit2
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module apmdc_top
    import apmdc_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // Shadow capture from floppy and UART write paths
    input  wire logic              fdc_rate_wr,
    input  wire logic [DATA_W-1:0] fdc_rate_data,
    input  wire logic              uart1_fcr_wr,
    input  wire logic [DATA_W-1:0] uart1_fcr_data,
    input  wire logic              uart2_fcr_wr,
    input  wire logic [DATA_W-1:0] uart2_fcr_data,
    // Floppy pins and status
    input  wire logic              step_pulse_n,
    input  wire logic              drive0_select_n,
    input  wire logic              drive1_select_n,
    input  wire logic              disk_changed_input_n,
    output logic                   disk_changed_status,
    // Internal sources for the muxed pins
    input  wire logic              uart2_rts_n,
    input  wire logic              uart2_dtr_n,
    input  wire logic              irq5,
    input  wire logic              irq6,
    input  wire logic              irq7,
    input  wire logic              irq10,
    input  wire logic              irq11,
    input  wire logic              irq12,
    input  wire logic              dma3_req,
    input  wire logic              kbc_port_bit2,
    input  wire logic              kbc_port_bit6,
    input  wire logic              system_mgmt_irq_n,
    // Internal results of the muxed pins
    output logic                   uart2_cts_n,
    output logic                   uart2_dsr_n,
    output logic                   uart2_dcd_n,
    output logic                   uart2_ri_n,
    output logic                   sa12,
    output logic                   sa13,
    output logic                   sa14,
    output logic                   sa15,
    // Request-to-send pin
    input  wire logic              uart2_request_to_send_pin_in,
    output logic                   uart2_request_to_send_pin_out,
    output logic                   uart2_request_to_send_pin_oe,
    // Clear-to-send pin
    input  wire logic              uart2_clear_to_send_pin_in,
    output logic                   uart2_clear_to_send_pin_out,
    output logic                   uart2_clear_to_send_pin_oe,
    // Terminal-ready pin
    input  wire logic              uart2_terminal_ready_pin_in,
    output logic                   uart2_terminal_ready_pin_out,
    output logic                   uart2_terminal_ready_pin_oe,
    // Set-ready pin
    input  wire logic              uart2_set_ready_pin_in,
    output logic                   uart2_set_ready_pin_out,
    output logic                   uart2_set_ready_pin_oe,
    // Carrier-detect pin
    input  wire logic              uart2_carrier_detect_pin_in,
    output logic                   uart2_carrier_detect_pin_out,
    output logic                   uart2_carrier_detect_pin_oe,
    // Ring-indicator pin
    input  wire logic              uart2_ring_indicator_pin_in,
    output logic                   uart2_ring_indicator_pin_out,
    output logic                   uart2_ring_indicator_pin_oe,
    // DMA3 request pin
    output logic                   dma3_request_pin
);

    logic [7:0]       pin_mux_r;
    logic [7:0]       force_r;
    logic [7:0]       rate_shadow_r;
    logic [7:0]       u1_fcr_r;
    logic [7:0]       u2_fcr_r;
    logic [7:0]       smi_en2_r;
    logic [7:0]       qual_r;
    logic [SYN_W-1:0] syn;
    logic             step_d_r;
    logic             step_fall;
    logic             set0;
    logic             set1;
    logic             clr0;
    logic             clr1;
    logic             wr_force;
    apmdc_mode_e      mode_a;
    apmdc_mode_e      mode_b;
    logic [5:0]       pin_out_nxt;
    logic [5:0]       pin_oe_nxt;
    logic [7:0]       int_nxt;
    logic             dma3_nxt;
    logic             dchg_nxt;
    logic [7:0]       rdata_nxt;

    apmdc_sync #(
        .WIDTH (SYN_W),
        .RST   (SYN_RST)
    ) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .d      ({uart2_ring_indicator_pin_in, uart2_carrier_detect_pin_in,
                  uart2_set_ready_pin_in, uart2_terminal_ready_pin_in,
                  uart2_clear_to_send_pin_in, uart2_request_to_send_pin_in,
                  disk_changed_input_n, drive1_select_n, drive0_select_n,
                  step_pulse_n}),
        .q      (syn)
    );

    // Configuration registers written by software
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_mux_r <= PIN_MUX_RST;
            smi_en2_r <= SMI_EN2_RST;
            qual_r    <= QUAL_RST;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_PIN_MUX) begin
                pin_mux_r <= reg_wdata & PIN_MUX_MASK;
            end else if (reg_addr == ADDR_SMI_EN2) begin
                smi_en2_r <= reg_wdata & SMI_EN2_MASK;
            end else if (reg_addr == ADDR_ADDR_QUAL) begin
                qual_r <= reg_wdata & QUAL_MASK;
            end
        end
    end

    // Step edge seen on the synchronised level, never on the first stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            step_d_r <= 1'b1;
        end else begin
            step_d_r <= syn[SYN_STEP];
        end
    end

    assign step_fall = step_d_r && !syn[SYN_STEP];
    assign wr_force  = reg_wr && (reg_addr == ADDR_FORCE_CHG);
    assign set0      = wr_force && reg_wdata[FORCE0_BIT];
    assign set1      = wr_force && reg_wdata[FORCE1_BIT];
    assign clr0      = step_fall && !syn[SYN_DS0];
    assign clr1      = step_fall && !syn[SYN_DS1];

    // Set beats a simultaneous step clear so a software force is never lost
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            force_r <= FORCE_RST;
        end else begin
            if (set0) begin
                force_r[FORCE0_BIT] <= 1'b1;
            end else if (clr0) begin
                force_r[FORCE0_BIT] <= 1'b0;
            end
            if (set1) begin
                force_r[FORCE1_BIT] <= 1'b1;
            end else if (clr1) begin
                force_r[FORCE1_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rate_shadow_r <= SHADOW_RST;
        end else if (fdc_rate_wr) begin
            rate_shadow_r <= fdc_rate_data & RATE_MASK;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            u1_fcr_r <= SHADOW_RST;
            u2_fcr_r <= SHADOW_RST;
        end else begin
            if (uart1_fcr_wr) begin
                u1_fcr_r <= uart1_fcr_data & FCR_MASK;
            end
            if (uart2_fcr_wr) begin
                u2_fcr_r <= uart2_fcr_data & FCR_MASK;
            end
        end
    end

    // Read decode; unmapped offsets answer zero
    always_comb begin
        if (reg_addr == ADDR_PIN_MUX) begin
            rdata_nxt = pin_mux_r;
        end else if (reg_addr == ADDR_FORCE_CHG) begin
            rdata_nxt = force_r & FORCE_MASK;
        end else if (reg_addr == ADDR_RATE_SHADOW) begin
            rdata_nxt = rate_shadow_r;
        end else if (reg_addr == ADDR_U1_FCR) begin
            rdata_nxt = u1_fcr_r;
        end else if (reg_addr == ADDR_U2_FCR) begin
            rdata_nxt = u2_fcr_r;
        end else if (reg_addr == ADDR_SMI_EN2) begin
            rdata_nxt = smi_en2_r;
        end else if (reg_addr == ADDR_ADDR_QUAL) begin
            rdata_nxt = qual_r;
        end else begin
            rdata_nxt = RD_UNMAPPED;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= RD_UNMAPPED;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= RD_UNMAPPED;
        end
    end

    // Modes follow the live configuration bits
    assign mode_a = apmdc_pin_mode(qual_r[QUAL_FULL_BIT], pin_mux_r[PMX_SERIRQ_BIT]);
    assign mode_b = apmdc_pin_mode(pin_mux_r[PMX_KBC_BIT], pin_mux_r[PMX_SERIRQ_BIT]);

    // Pin order in vectors: rts, cts, dtr, dsr, dcd, ri
    // Internal order: cts_n, dsr_n, dcd_n, ri_n, sa12..sa15
    always_comb begin
        pin_out_nxt = 6'h00;
        pin_oe_nxt  = 6'h00;
        int_nxt     = 8'h0f;
        case (mode_a)
            MODE_MODEM: begin pin_out_nxt[0] = uart2_rts_n; pin_oe_nxt[0] = 1'b1; end
            MODE_IRQ:   begin pin_out_nxt[0] = irq5;        pin_oe_nxt[0] = 1'b1; end
            MODE_ALT:   int_nxt[4] = syn[SYN_RTS];
            default:    pin_oe_nxt[0] = 1'b0;
        endcase
        case (mode_a)
            MODE_MODEM: int_nxt[0] = syn[SYN_CTS];
            MODE_IRQ:   begin pin_out_nxt[1] = irq6; pin_oe_nxt[1] = 1'b1; end
            MODE_ALT:   int_nxt[5] = syn[SYN_CTS];
            default:    pin_oe_nxt[1] = 1'b0;
        endcase
        case (mode_a)
            MODE_MODEM: begin pin_out_nxt[2] = uart2_dtr_n; pin_oe_nxt[2] = 1'b1; end
            MODE_IRQ:   begin pin_out_nxt[2] = irq7;        pin_oe_nxt[2] = 1'b1; end
            MODE_ALT:   int_nxt[6] = syn[SYN_DTR];
            default:    pin_oe_nxt[2] = 1'b0;
        endcase
        case (mode_a)
            MODE_MODEM: int_nxt[1] = syn[SYN_DSR];
            MODE_IRQ: begin
                pin_out_nxt[3] = smi_en2_r[SMI_IRQ10_BIT] ? !system_mgmt_irq_n : irq10;
                pin_oe_nxt[3]  = 1'b1;
            end
            MODE_ALT:   int_nxt[7] = syn[SYN_DSR];
            default:    pin_oe_nxt[3] = 1'b0;
        endcase
        case (mode_b)
            MODE_MODEM: int_nxt[2] = syn[SYN_DCD];
            MODE_IRQ:   begin pin_out_nxt[4] = irq11;         pin_oe_nxt[4] = 1'b1; end
            MODE_ALT:   begin pin_out_nxt[4] = kbc_port_bit2; pin_oe_nxt[4] = 1'b1; end
            default:    pin_oe_nxt[4] = 1'b0;
        endcase
        case (mode_b)
            MODE_MODEM: int_nxt[3] = syn[SYN_RI];
            MODE_IRQ:   begin pin_out_nxt[5] = irq12;         pin_oe_nxt[5] = 1'b1; end
            MODE_ALT:   begin pin_out_nxt[5] = kbc_port_bit6; pin_oe_nxt[5] = 1'b1; end
            default:    pin_oe_nxt[5] = 1'b0;
        endcase
    end

    assign dma3_nxt = pin_mux_r[PMX_DMA3_BIT] ? dma3_req : kbc_port_bit2;

    assign dchg_nxt = (syn[SYN_DS0] && force_r[FORCE0_BIT]) ||
                      (syn[SYN_DS1] && force_r[FORCE1_BIT]) || syn[SYN_DCHG];

    // All pin and status outputs registered; one cycle after a config write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {uart2_ring_indicator_pin_out, uart2_carrier_detect_pin_out,
             uart2_set_ready_pin_out, uart2_terminal_ready_pin_out,
             uart2_clear_to_send_pin_out, uart2_request_to_send_pin_out} <= 6'h00;
            {uart2_ring_indicator_pin_oe, uart2_carrier_detect_pin_oe,
             uart2_set_ready_pin_oe, uart2_terminal_ready_pin_oe,
             uart2_clear_to_send_pin_oe, uart2_request_to_send_pin_oe} <= 6'h00;
            {sa15, sa14, sa13, sa12, uart2_ri_n, uart2_dcd_n,
             uart2_dsr_n, uart2_cts_n} <= 8'h0f;
            dma3_request_pin    <= 1'b0;
            disk_changed_status <= 1'b1;
        end else begin
            {uart2_ring_indicator_pin_out, uart2_carrier_detect_pin_out,
             uart2_set_ready_pin_out, uart2_terminal_ready_pin_out,
             uart2_clear_to_send_pin_out, uart2_request_to_send_pin_out} <= pin_out_nxt;
            {uart2_ring_indicator_pin_oe, uart2_carrier_detect_pin_oe,
             uart2_set_ready_pin_oe, uart2_terminal_ready_pin_oe,
             uart2_clear_to_send_pin_oe, uart2_request_to_send_pin_oe} <= pin_oe_nxt;
            {sa15, sa14, sa13, sa12, uart2_ri_n, uart2_dcd_n,
             uart2_dsr_n, uart2_cts_n} <= int_nxt;
            dma3_request_pin    <= dma3_nxt;
            disk_changed_status <= dchg_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    force_set_a: assert property (
        wr_force && reg_wdata[FORCE0_BIT] && reg_wdata[FORCE1_BIT]
        |=> force_r[FORCE0_BIT] && force_r[FORCE1_BIT])
        else $error("force flags not set by write of one");

    force_keep_a: assert property (
        wr_force && !reg_wdata[FORCE0_BIT] && force_r[FORCE0_BIT] && !clr0
        |=> force_r[FORCE0_BIT])
        else $error("force flag zero cleared by software");

    force1_clear_a: assert property (
        clr1 && !set1 |=> !force_r[FORCE1_BIT])
        else $error("force flag one not cleared by step");

    force0_clear_a: assert property (
        clr0 && !set0 |=> !force_r[FORCE0_BIT])
        else $error("force flag zero not cleared by step");

    disk_status_a: assert property (
        ##1 disk_changed_status == (($past(syn[SYN_DS0]) && $past(force_r[FORCE0_BIT])) ||
                                    ($past(syn[SYN_DS1]) && $past(force_r[FORCE1_BIT])) ||
                                    $past(syn[SYN_DCHG])))
        else $error("disk changed status mismatch");

    rate_shadow_a: assert property (
        fdc_rate_wr |=> rate_shadow_r == ($past(fdc_rate_data) & RATE_MASK))
        else $error("rate shadow capture mismatch");

    rate_read_a: assert property (
        reg_rd && reg_addr == ADDR_RATE_SHADOW |=> reg_rdata == $past(rate_shadow_r))
        else $error("rate shadow read mismatch");

    fcr_shadow_a: assert property (
        uart2_fcr_wr && !uart1_fcr_wr
        |=> u2_fcr_r == ($past(uart2_fcr_data) & FCR_MASK) && $stable(u1_fcr_r))
        else $error("uart fifo control shadow mismatch");

    rts_route_a: assert property (
        $past(arst_n) && mode_a == MODE_MODEM |=> uart2_request_to_send_pin_oe &&
                                 uart2_request_to_send_pin_out == $past(uart2_rts_n))
        else $error("request-to-send not routed to modem output");

    cts_addr_a: assert property (
        mode_a != MODE_ALT |=> !sa13)
        else $error("unused address input not zero");

    dsr_smi_a: assert property (
        mode_a == MODE_IRQ && smi_en2_r[SMI_IRQ10_BIT]
        |=> uart2_set_ready_pin_out == !$past(system_mgmt_irq_n))
        else $error("management interrupt not on set-ready pin");

    ri_kbc_a: assert property (
        mode_b == MODE_ALT |=> uart2_ring_indicator_pin_oe &&
                               uart2_ring_indicator_pin_out == $past(kbc_port_bit6) &&
                               uart2_ri_n)
        else $error("ring pin not carrying keyboard bit6");

    dma3_route_a: assert property (
        !pin_mux_r[PMX_DMA3_BIT] |=> dma3_request_pin == $past(kbc_port_bit2))
        else $error("dma3 pin not carrying keyboard bit2");

    rsvd_float_a: assert property (
        mode_a == MODE_RSVD |=> !uart2_request_to_send_pin_oe &&
                                !uart2_clear_to_send_pin_oe &&
                                !uart2_terminal_ready_pin_oe && !uart2_set_ready_pin_oe)
        else $error("reserved mode drives a pin");

endmodule

// file: sim/apmdc_far_end.sv
// Far-end model of the six shared serial pins and their external drivers
`timescale 1ns/1ps
module apmdc_far_end (
    // Block side of each pin
    input  wire logic [5:0] oe,
    input  wire logic [5:0] out,
    // External level, driven whenever the block lets go of a pin
    input  wire logic [5:0] ext,
    // Resolved wire level
    output logic      [5:0] pin
);
    // External parts always drive, so a released pin never floats in this model
    assign pin = (oe & out) | (~oe & ext);
endmodule

// file: sim/aux_pin_mux_disk_change_tb.sv
// Self-checking bench for the auxiliary pin mux and disk change block
`timescale 1ns/1ps
module aux_pin_mux_disk_change_tb;
    logic       clk, arst_n, reg_wr, reg_rd, fdc_rate_wr, uart1_fcr_wr, uart2_fcr_wr;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, fdc_rate_data, uart1_fcr_data, uart2_fcr_data;
    logic       step_pulse_n, drive0_select_n, drive1_select_n;
    logic       disk_changed_input_n, disk_changed_status, uart2_rts_n, uart2_dtr_n;
    logic       irq5, irq6, irq7, irq10, irq11, irq12, dma3_req;
    logic       kbc_port_bit2, kbc_port_bit6, system_mgmt_irq_n, dma3_request_pin;
    logic       uart2_cts_n, uart2_dsr_n, uart2_dcd_n, uart2_ri_n, sa12, sa13, sa14, sa15;
    logic [5:0] oe, po, pin, ext;
    logic [4:0] c;
    logic [1:0] ma, mb;
    logic [31:0] r;
    logic [7:0] u1e;
    int         miscompares, checks_done;

    apmdc_top uut (
        .*,
        .uart2_request_to_send_pin_in (pin[0]),
        .uart2_request_to_send_pin_out(po[0]),
        .uart2_request_to_send_pin_oe (oe[0]),
        .uart2_clear_to_send_pin_in   (pin[1]),
        .uart2_clear_to_send_pin_out  (po[1]),
        .uart2_clear_to_send_pin_oe   (oe[1]),
        .uart2_terminal_ready_pin_in  (pin[2]),
        .uart2_terminal_ready_pin_out (po[2]),
        .uart2_terminal_ready_pin_oe  (oe[2]),
        .uart2_set_ready_pin_in       (pin[3]),
        .uart2_set_ready_pin_out      (po[3]),
        .uart2_set_ready_pin_oe       (oe[3]),
        .uart2_carrier_detect_pin_in  (pin[4]),
        .uart2_carrier_detect_pin_out (po[4]),
        .uart2_carrier_detect_pin_oe  (oe[4]),
        .uart2_ring_indicator_pin_in  (pin[5]),
        .uart2_ring_indicator_pin_out (po[5]),
        .uart2_ring_indicator_pin_oe  (oe[5])
    );

    apmdc_far_end far (.oe(oe), .out(po), .ext(ext), .pin(pin));

    always #5 clk = ~clk;

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    // Pulse wide enough for the pin synchronisers on both levels
    task step(input logic s0, input logic s1);
        @(posedge clk);
        drive0_select_n <= s0;
        drive1_select_n <= s1;
        repeat (3) @(posedge clk);
        step_pulse_n <= 1'b0;
        repeat (3) @(posedge clk);
        step_pulse_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    function automatic logic dsk(input logic [1:0] f);
        return (drive0_select_n & f[0]) | (drive1_select_n & f[1]) | disk_changed_input_n;
    endfunction

    // Expected {oe, out, internal modem input, address input} of one shared pin
    function automatic logic [3:0] ex(input logic [1:0] m, input logic drv, input logic src,
                                      input logic irq, input logic ao, input logic asrc,
                                      input logic p);
        case (m)
            2'b00: ex = {drv, drv & src, drv | p, 1'b0};
            2'b01: ex = {1'b1, irq, 2'b10};
            2'b10: ex = {ao, ao & asrc, 1'b1, ~ao & p};
            default: ex = 4'b0010;
        endcase
    endfunction

    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        complete_run;
    end

    initial begin
        {clk, arst_n, reg_wr, reg_rd, fdc_rate_wr, uart1_fcr_wr, uart2_fcr_wr} = '0;
        {reg_addr, reg_wdata, fdc_rate_data, uart1_fcr_data, uart2_fcr_data} = '0;
        {step_pulse_n, drive0_select_n, drive1_select_n, disk_changed_input_n} = 4'hf;
        {uart2_rts_n, uart2_dtr_n, irq5, irq6, irq7, irq10, irq11, irq12} = '0;
        {dma3_req, kbc_port_bit2, kbc_port_bit6, system_mgmt_irq_n} = 4'h1;
        ext = 6'h3f;
        void'($urandom(73));
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        rd(8'hc0, 8'h06);
        rd(8'hc1, 8'h03);
        rd(8'h55, 8'h00);
        $display("test reset done");
        disk_changed_input_n <= 1'b0;
        wr(8'hc1, 8'h00);
        rd(8'hc1, 8'h03);
        step(1'b0, 1'b1);
        rd(8'hc1, 8'h02);
        chk(disk_changed_status, dsk(2'b10));
        step(1'b1, 1'b0);
        rd(8'hc1, 8'h00);
        chk(disk_changed_status, dsk(2'b00));
        wr(8'hc1, 8'h01);
        rd(8'hc1, 8'h01);
        chk(disk_changed_status, dsk(2'b01));
        wr(8'hc1, 8'h03);
        rd(8'hc1, 8'h03);
        $display("test force flags done");
        for (int i = 0; i < 4; i++) begin
            r = i ? $urandom : '1;
            @(posedge clk);
            {fdc_rate_wr, uart1_fcr_wr, uart2_fcr_wr} <= {1'b1, i != 3, 1'b1};
            u1e = (i == 3) ? u1e : r[15:8];
            {fdc_rate_data, uart1_fcr_data, uart2_fcr_data} <= r[23:0];
            @(posedge clk);
            {fdc_rate_wr, uart1_fcr_wr, uart2_fcr_wr} <= 3'h0;
            wr(8'hc2, ~r[23:16]);
            rd(8'hc2, r[23:16] & 8'hdf);
            rd(8'hc3, u1e & 8'hcf);
            rd(8'hc4, r[7:0] & 8'hcf);
        end
        $display("test shadows done");
        for (int i = 0; i < 64; i++) begin
            c = 5'(i);
            wr(8'hc0, {4'h0, c[2], c[1], c[3], 1'b0});
            wr(8'hd0, {1'b0, c[0], 6'h0});
            wr(8'hb5, {c[4], 7'h0});
            {uart2_rts_n, uart2_dtr_n, irq5, irq6, irq7, irq10, irq11, irq12} <= 8'($urandom);
            {dma3_req, kbc_port_bit2, kbc_port_bit6, system_mgmt_irq_n} <= 4'($urandom);
            ext <= 6'($urandom);
            ma = {c[0], ~c[1]};
            mb = {c[2], ~c[1]};
            repeat (5) @(posedge clk);
            #1;
            chk({oe[0], po[0], 1'b1, sa12},
                ex(ma, 1, uart2_rts_n, irq5, 0, 0, pin[0]));
            chk({oe[1], po[1], uart2_cts_n, sa13}, ex(ma, 0, 0, irq6, 0, 0, pin[1]));
            chk({oe[2], po[2], 1'b1, sa14}, ex(ma, 1, uart2_dtr_n, irq7, 0, 0, pin[2]));
            chk({oe[3], po[3], uart2_dsr_n, sa15},
                ex(ma, 0, 0, c[4] ? ~system_mgmt_irq_n : irq10, 0, 0, pin[3]));
            chk({oe[4], po[4], uart2_dcd_n, 1'b0},
                ex(mb, 0, 0, irq11, 1, kbc_port_bit2, pin[4]));
            chk({oe[5], po[5], uart2_ri_n, 1'b0},
                ex(mb, 0, 0, irq12, 1, kbc_port_bit6, pin[5]));
            chk(dma3_request_pin, c[3] ? dma3_req : kbc_port_bit2);
        end
        $display("test pin mux done");
        complete_run;
    end
endmodule
